// ==== inc/ecs_consts.svh ====
// register numbers, field values and reset values of the sample clock select logic
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH

`define ECS_ADDR_W              16
`define ECS_REG_EXT_SELECT      16'h4E84
`define ECS_REG_DIVIDER         16'h4E48
`define ECS_REG_CLOCK_OUT       16'h4E8E
`define ECS_REG_TERMINATION     16'h4E98
`define ECS_REG_RANGE           16'h4EA2

`define ECS_RANGE_SINGLE        32'h0000_0002
`define ECS_RANGE_SMALL_BURST   32'h0000_0004
`define ECS_RANGE_MEDIUM_BURST  32'h0000_0008
`define ECS_RANGE_LARGE_BURST   32'h0000_0010
`define ECS_RANGE_XL_BURST      32'h0000_0020

`define ECS_RST_DIVIDER         32'h0000_0001
`define ECS_RST_RANGE           32'h0000_0002
`define ECS_DIV_CNT_W           11

`endif

// ==== inc/ecs_pkg.sv ====
// types of the sample clock select logic
package ecs_pkg;

	typedef enum logic [2:0] {
		ECS_BAND_SINGLE = 3'h0,
		ECS_BAND_SMALL  = 3'h1,
		ECS_BAND_MEDIUM = 3'h2,
		ECS_BAND_LARGE  = 3'h3,
		ECS_BAND_XL     = 3'h4
	} ecs_band_t;

endpackage

// ==== design/ecs_divider.sv ====
// programmable divider producing a one-cycle tick every n-th external clock edge
`timescale 1ns/100ps
`include "ecs_consts.svh"

module ecs_divider
	import ecs_pkg::*;
#(
	parameter int CNT_W = `ECS_DIV_CNT_W
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	// control
	input  wire logic [CNT_W-1:0] i_divisor,
	input  wire logic             i_edge,
	// result
	output logic                  o_tick
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;

	always_comb begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (i_edge) begin
			// a divisor change takes effect at the next edge; a count at or above the new limit wraps at once
			if (cnt_reg >= i_divisor - CNT_W'(1)) begin
				cnt_next  = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;

endmodule // ecs_divider

// ==== design/ecs_clock_select.sv ====
// sample clock source select, external divider, range and termination control
// Notes on behaviour
// - external select picks connector clock, else internal
// - termination write enables 110 Ohm when input
// - external clock accepted down to DC
// - range takes one-of-five code, drives clocking band
// - divider divides external clock by allowed value
// - clock output only under internal clocking
`timescale 1ns/100ps
`include "ecs_consts.svh"

module ecs_clock_select
	import ecs_pkg::*;
(
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	// register port
	input  wire logic [`ECS_ADDR_W-1:0] i_reg_addr,
	input  wire logic                   i_reg_wr,
	input  wire logic [31:0]            i_reg_wdata,
	output logic      [31:0]            o_reg_rdata,
	// clock sources
	input  wire logic                   i_int_sample_tick,
	input  wire logic                   i_ext_clk_pin,
	// connector control
	output logic                        o_term_enable,
	output logic                        o_conn_clk_o,
	output logic                        o_conn_clk_oe,
	// sample clock to the timing logic
	output logic                        o_sample_tick,
	output logic                        o_ext_active,
	output ecs_band_t                   o_band
);

	// registers
	logic        ext_sel_reg,   ext_sel_next;
	logic        term_reg,      term_next;
	logic        clk_out_reg,   clk_out_next;
	logic [31:0] range_reg,     range_next;
	logic [31:0] div_reg,       div_next;
	logic [31:0] rdata_reg,     rdata_next;

	// external pin crossing and edge detection
	logic [2:0]  ext_sync_reg,  ext_sync_next;
	logic        ext_rise;

	// outputs
	logic        tick_reg,      tick_next;
	logic        conn_o_reg,    conn_o_next;
	logic        conn_oe_reg,   conn_oe_next;
	logic        term_out_reg,  term_out_next;
	logic        ext_act_reg,   ext_act_next;
	ecs_band_t   band_reg,      band_next;

	logic        div_tick;
	logic        div_valid;
	logic [`ECS_DIV_CNT_W-1:0] div_value;

	// only listed divisors accepted; others leave the old value in place
	function automatic logic allowed_div(input logic [31:0] v);
		unique case (v)
			32'h1, 32'h2, 32'h4, 32'h8, 32'hA, 32'h10, 32'h14, 32'h28, 32'h32,
			32'h50, 32'h64, 32'hC8, 32'h190, 32'h1F4, 32'h320, 32'h3E8,
			32'h7D0: allowed_div = 1'b1;
			default: allowed_div = 1'b0;
		endcase
	endfunction

	function automatic logic allowed_range(input logic [31:0] v);
		unique case (v)
			`ECS_RANGE_SINGLE, `ECS_RANGE_SMALL_BURST, `ECS_RANGE_MEDIUM_BURST,
			`ECS_RANGE_LARGE_BURST, `ECS_RANGE_XL_BURST: allowed_range = 1'b1;
			default: allowed_range = 1'b0;
		endcase
	endfunction

	assign div_valid = allowed_div(i_reg_wdata);
	assign div_value = div_reg[`ECS_DIV_CNT_W-1:0];

	// register writes
	always_comb begin
		ext_sel_next = ext_sel_reg;
		term_next    = term_reg;
		clk_out_next = clk_out_reg;
		range_next   = range_reg;
		div_next     = div_reg;
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				`ECS_REG_EXT_SELECT:  ext_sel_next = i_reg_wdata[0];
				`ECS_REG_TERMINATION: term_next    = i_reg_wdata[0];
				`ECS_REG_CLOCK_OUT:   clk_out_next = i_reg_wdata[0];
				`ECS_REG_RANGE: begin
					if (allowed_range(i_reg_wdata)) begin
						range_next = i_reg_wdata;
					end
				end
				`ECS_REG_DIVIDER: begin
					if (div_valid) begin
						div_next = i_reg_wdata;
					end
				end
				default: ;
			endcase
		end
	end

	// read data, registered one cycle after the address
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (i_reg_addr)
			`ECS_REG_EXT_SELECT:  rdata_next = {31'h0, ext_sel_reg};
			`ECS_REG_TERMINATION: rdata_next = {31'h0, term_reg};
			`ECS_REG_CLOCK_OUT:   rdata_next = {31'h0, clk_out_reg};
			`ECS_REG_RANGE:       rdata_next = range_reg;
			`ECS_REG_DIVIDER:     rdata_next = div_reg;
			default:              rdata_next = 32'h0000_0000;
		endcase
	end

	// pin synchroniser; stage 0 is read only by stage 1.
	// edges are detected by level, so a stopped clock simply gives no ticks (down to DC)
	always_comb begin
		ext_sync_next = {ext_sync_reg[1:0], i_ext_clk_pin};
	end
	assign ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];

	ecs_divider #(
		.CNT_W     (`ECS_DIV_CNT_W)
	) u_divider (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_divisor (div_value),
		.i_edge    (ext_rise & ext_sel_reg),
		.o_tick    (div_tick)
	);

	// source select and connector control
	always_comb begin
		band_next = band_reg;
		unique case (range_reg)
			`ECS_RANGE_SINGLE:       band_next = ECS_BAND_SINGLE;
			`ECS_RANGE_SMALL_BURST:  band_next = ECS_BAND_SMALL;
			`ECS_RANGE_MEDIUM_BURST: band_next = ECS_BAND_MEDIUM;
			`ECS_RANGE_LARGE_BURST:  band_next = ECS_BAND_LARGE;
			`ECS_RANGE_XL_BURST:     band_next = ECS_BAND_XL;
			default:                 band_next = band_reg;
		endcase
		ext_act_next  = ext_sel_reg;
		tick_next     = ext_sel_reg ? div_tick : i_int_sample_tick;
		// never drive the connector while it is an input; output only on internal clock
		conn_oe_next  = clk_out_reg & ~ext_sel_reg;
		conn_o_next   = conn_oe_next & i_int_sample_tick;
		// termination is meaningless while driving, so it is held off then
		term_out_next = term_reg & ~conn_oe_next;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ext_sel_reg  <= 1'b0;
			term_reg     <= 1'b0;
			clk_out_reg  <= 1'b0;
			range_reg    <= `ECS_RST_RANGE;
			div_reg      <= `ECS_RST_DIVIDER;
			rdata_reg    <= 32'h0000_0000;
			ext_sync_reg <= 3'h0;
			tick_reg     <= 1'b0;
			conn_o_reg   <= 1'b0;
			conn_oe_reg  <= 1'b0;
			term_out_reg <= 1'b0;
			ext_act_reg  <= 1'b0;
			band_reg     <= ECS_BAND_SINGLE;
		end else begin
			ext_sel_reg  <= ext_sel_next;
			term_reg     <= term_next;
			clk_out_reg  <= clk_out_next;
			range_reg    <= range_next;
			div_reg      <= div_next;
			rdata_reg    <= rdata_next;
			ext_sync_reg <= ext_sync_next;
			tick_reg     <= tick_next;
			conn_o_reg   <= conn_o_next;
			conn_oe_reg  <= conn_oe_next;
			term_out_reg <= term_out_next;
			ext_act_reg  <= ext_act_next;
			band_reg     <= band_next;
		end
	end

	assign o_reg_rdata   = rdata_reg;
	assign o_term_enable = term_out_reg;
	assign o_conn_clk_o  = conn_o_reg;
	assign o_conn_clk_oe = conn_oe_reg;
	assign o_sample_tick = tick_reg;
	assign o_ext_active  = ext_act_reg;
	assign o_band        = band_reg;

endmodule // ecs_clock_select

// ==== verif/ecs_clock_select_properties.sv ====
// assertions on the sample clock select ports
`timescale 1ns/100ps
`include "ecs_consts.svh"
module ecs_cs_props
	import ecs_pkg::*;
(
	// clock, reset, register writes and internal tick
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic [15:0] i_reg_addr,
	input wire logic        i_reg_wr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic        i_int_sample_tick,
	// controls and ticks
	input wire logic        o_term_enable,
	input wire logic        o_conn_clk_o,
	input wire logic        o_conn_clk_oe,
	input wire logic        o_sample_tick,
	input wire logic        o_ext_active,
	input wire ecs_band_t   o_band
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// band expected for each accepted range code
	function automatic logic [2:0] band_of(input logic [31:0] c);
		case (c)
			`ECS_RANGE_SMALL_BURST:  band_of = 3'h1;
			`ECS_RANGE_MEDIUM_BURST: band_of = 3'h2;
			`ECS_RANGE_LARGE_BURST:  band_of = 3'h3;
			`ECS_RANGE_XL_BURST:     band_of = 3'h4;
			default:                 band_of = 3'h0;
		endcase
	endfunction
	sequence s_int;
		!o_ext_active && i_int_sample_tick ##1 !o_ext_active [*2];
	endsequence
	sequence s_bad_rng;
		i_reg_wr && i_reg_addr == `ECS_REG_RANGE
			&& !(i_reg_wdata inside {2, 4, 8, 16, 32}) ##1 !i_reg_wr;
	endsequence
	property p_band;
		logic [2:0] b;
		(i_reg_wr && i_reg_addr == `ECS_REG_RANGE && i_reg_wdata inside {2, 4, 8, 16, 32},
			b = band_of(i_reg_wdata)) ##1 !i_reg_wr |-> ##1 o_band == b;
	endproperty
	property p_sel;
		logic v;
		(i_reg_wr && i_reg_addr == `ECS_REG_EXT_SELECT, v = i_reg_wdata[0]) ##1 !i_reg_wr
			|-> ##1 o_ext_active == v;
	endproperty
	// the connector carries the internal tick while it is driven
	property p_copy;
		o_conn_clk_oe && $past(o_conn_clk_oe) |-> o_conn_clk_o == $past(i_int_sample_tick);
	endproperty
	property p_rst;
		$fell(i_sys_rst) |-> !o_ext_active && !o_term_enable && !o_conn_clk_oe
			&& o_band == ECS_BAND_SINGLE;
	endproperty
	a_int_tick_pass: assert property (s_int |-> $past(o_sample_tick))
		else $error("internal tick lost");
	a_sel_follows: assert property (p_sel)
		else $error("select not followed");
	a_term_off_drive: assert property (o_term_enable |-> !o_conn_clk_oe)
		else $error("termination while driving");
	a_band_code: assert property (p_band)
		else $error("band mismatch");
	// a write just before the refused one may still be landing on the band one edge later
	a_range_refused: assert property (s_bad_rng |-> ##1 $stable(o_band) [*2])
		else $error("refused code changed band");
	a_oe_internal: assert property (o_conn_clk_oe |-> !o_ext_active)
		else $error("driven under external clock");
	a_conn_copy: assert property (p_copy)
		else $error("connector not the tick");
	a_reset_state: assert property (p_rst)
		else $error("bad state after reset");
endmodule // ecs_cs_props
bind ecs_clock_select ecs_cs_props chk_u (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr,
	.i_reg_wdata, .i_int_sample_tick, .o_term_enable, .o_conn_clk_o, .o_conn_clk_oe,
	.o_sample_tick, .o_ext_active, .o_band);

// ==== verif/ecs_ext_clk_gen.sv ====
// external clock generator model driving the clock connector
`timescale 1ns/100ps
module ecs_ext_clk_gen #(
	parameter int HALF_NS = 60
) (
	// control
	input  wire logic i_run,
	// connector
	output logic      o_pin
);
	// below the slowest maximum rate, above 1 MS/s; held low between bursts
	initial begin
		o_pin = 1'b0;
		forever begin
			#(HALF_NS);
			o_pin = i_run ? ~o_pin : 1'b0;
		end
	end
endmodule // ecs_ext_clk_gen

// ==== verif/ecs_clock_select_tb_top.sv ====
// bench for the sample clock select logic
`timescale 1ns/100ps
`include "ecs_consts.svh"
module ecs_clock_select_tb_top;
	import ecs_pkg::*;
	logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, run = 1'b0;
	logic        i_int_sample_tick = 1'b0, i_ext_clk_pin;
	logic [15:0] i_reg_addr = 16'h0;
	logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
	logic        o_term_enable, o_conn_clk_o, o_conn_clk_oe, o_sample_tick, o_ext_active;
	ecs_band_t   o_band;
	int          mismatches = 0, num_checks = 0, ticks = 0, ph = 0;
	ecs_clock_select dut_u (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
		.o_reg_rdata, .i_int_sample_tick, .i_ext_clk_pin, .o_term_enable, .o_conn_clk_o,
		.o_conn_clk_oe, .o_sample_tick, .o_ext_active, .o_band);
	ecs_ext_clk_gen gen_u (.i_run(run), .o_pin(i_ext_clk_pin));
	initial forever #4 i_clk = ~i_clk;
	// internal tick every tenth cycle, also while external clocking must mask it
	always @(negedge i_clk) begin
		ph <= (ph == 9) ? 0 : ph + 1;
		i_int_sample_tick <= (ph == 9);
	end
	always @(posedge i_clk) if (o_sample_tick === 1'b1) ticks++;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// controls settle one edge after the write edge
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge i_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_clk);
		i_reg_wr = 1'b0;
		repeat (2) @(negedge i_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(negedge i_clk);
		i_reg_addr = a;
		@(negedge i_clk);
		chk(o_reg_rdata, exp);
	endtask
	task automatic ext_edges(input int n, input int exp);
		ticks = 0;
		run = 1'b1;
		repeat (n) @(posedge i_ext_clk_pin);
		run = 1'b0;
		repeat (20) @(negedge i_clk);
		chk(ticks, exp);
	endtask
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	initial begin
		repeat (12) @(negedge i_clk);
		i_sys_rst = 1'b0;
		rd(`ECS_REG_DIVIDER, `ECS_RST_DIVIDER);
		rd(`ECS_REG_EXT_SELECT, 32'h0);
		chk({o_ext_active, o_term_enable, o_conn_clk_oe}, 32'h0);
		wr(`ECS_REG_CLOCK_OUT, 32'h1);
		wr(`ECS_REG_TERMINATION, 32'h1);
		chk(o_conn_clk_oe, 32'h1);
		chk(o_term_enable, 32'h0);
		ticks = 0;
		repeat (100) @(negedge i_clk);
		chk(ticks, 32'd10);
		wr(`ECS_REG_CLOCK_OUT, 32'h0);
		chk(o_term_enable, 32'h1);
		// last code is refused and the previous one stays
		for (int i = 0; i < 6; i++) begin
			wr(`ECS_REG_RANGE, 32'h2 << i);
			rd(`ECS_REG_RANGE, 32'h2 << ((i < 5) ? i : 4));
			chk(o_band, (i < 5) ? i : 4);
		end
		wr(`ECS_REG_DIVIDER, 32'h3);
		rd(`ECS_REG_DIVIDER, 32'h1);
		wr(`ECS_REG_EXT_SELECT, 32'h1);
		chk(o_ext_active, 32'h1);
		wr(`ECS_REG_CLOCK_OUT, 32'h1);
		chk(o_conn_clk_oe, 32'h0);
		chk(o_term_enable, 32'h1);
		// the generator runs near 8 MS/s, below the single band limit of one 8-bit channel
		wr(`ECS_REG_RANGE, `ECS_RANGE_SINGLE);
		ext_edges(3, 3);
		wr(`ECS_REG_DIVIDER, 32'h4);
		ext_edges(16, 4);
		// reset in mid-run, with external clocking, termination and divider set
		@(negedge i_clk);
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_sys_rst = 1'b0;
		rd(`ECS_REG_DIVIDER, `ECS_RST_DIVIDER);
		rd(`ECS_REG_TERMINATION, 32'h0);
		chk({o_ext_active, o_term_enable, o_conn_clk_oe}, 32'h0);
		end_of_test();
	end
endmodule // ecs_clock_select_tb_top
